// ===== logic/urd_pkg.sv
package urd_pkg;

  // Setup packet field positions, little-endian byte order
  localparam int SETUP_W = 64;
  localparam int BMRT_LSB = 0;
  localparam int BREQ_LSB = 8;
  localparam int WVAL_LSB = 16;
  localparam int WIDX_LSB = 32;
  localparam int WLEN_LSB = 48;
  localparam int DIR_BIT = 7;

  localparam logic [1:0] RT_STD = 2'h0;
  localparam logic [1:0] RT_VENDOR = 2'h2;
  localparam logic [4:0] RCP_DEVICE = 5'h00;
  localparam logic [4:0] RCP_IFACE = 5'h01;
  localparam logic [4:0] RCP_EP = 5'h02;

  localparam logic [7:0] REQ_GET_STATUS = 8'h00;
  localparam logic [7:0] REQ_CLEAR_FEATURE = 8'h01;
  localparam logic [7:0] REQ_SET_FEATURE = 8'h03;
  localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
  localparam logic [7:0] REQ_GET_DESCRIPTOR = 8'h06;
  localparam logic [7:0] REQ_GET_CONFIG = 8'h08;
  localparam logic [7:0] REQ_SET_CONFIG = 8'h09;
  localparam logic [7:0] REQ_GET_IFACE = 8'h0A;
  localparam logic [7:0] REQ_SET_IFACE = 8'h0B;

  localparam logic [7:0] DESC_DEVICE = 8'h01;
  localparam logic [7:0] DESC_CONFIG = 8'h02;
  localparam logic [15:0] FEAT_REMOTE_WAKEUP = 16'h0001;
  localparam logic [15:0] ADDR_MIN = 16'h0001;
  localparam logic [15:0] ADDR_MAX = 16'h001F;
  localparam logic [15:0] CFG_MAX = 16'h0001;
  localparam logic [15:0] ALT_MAX = 16'h0003;
  localparam logic [15:0] IFACE_NUM = 16'h0000;
  localparam logic [15:0] EP_MAX = 16'h0003;

  // Vendor command classes and special command codes
  localparam logic [7:0] CLASS_CONTROL = 8'h00;
  localparam logic [7:0] BUS_COMMUNICATION_CLASS = 8'h01;
  localparam logic [7:0] CLASS_MODE = 8'h02;
  localparam logic [15:0] COMMAND_QUEUE_READBACK = 16'h000D;
  localparam logic [7:0] DIRECT_READ_COMMAND = 8'h80;

  // Endpoint figures; poll and bulk size vary per alternate setting
  localparam logic [3:0] POLL_LONG_MS = 4'hA;
  localparam logic [3:0] POLL_SHORT_MS = 4'h1;
  localparam logic [6:0] BULK_SMALL = 7'h10;
  localparam logic [6:0] BULK_LARGE = 7'h40;
  localparam logic [6:0] INTR_MAX_PKT = 7'h20;
  localparam logic [6:0] CTRL_MAX_PKT = 7'h08;

  localparam logic [15:0] STATUS_LEN = 16'h0002;
  localparam logic [15:0] ONE_LEN = 16'h0001;
  localparam logic [15:0] DESC_LEN = 16'h0008;

  // Answer stream entry: {last, stall, data byte}
  localparam int ENT_W = 10;
  localparam int ENT_LAST = 9;
  localparam int ENT_STALL = 8;
  localparam int FIFO_DEPTH = 8;

  localparam logic [7:0] DEV_DESC [8] = '{8'h12, 8'h01, 8'h10, 8'h01,
    8'hFF, 8'h00, 8'hFF, 8'h08};
  localparam logic [7:0] CFG_DESC [8] = '{8'h09, 8'h02, 8'h2E, 8'h00,
    8'h01, 8'h01, 8'h00, 8'hA0};

  typedef enum logic [2:0] {
    URD_IDLE = 3'b001,
    URD_SEND = 3'b010,
    URD_DONE = 3'b100
  } urd_state_t;

  typedef enum logic [1:0] {
    URD_K_VAL = 2'h0,
    URD_K_DEV = 2'h1,
    URD_K_CFG = 2'h2,
    URD_K_QUEUE = 2'h3
  } urd_kind_t;

  function automatic logic [15:0] urd_min(input logic [15:0] a,
                                          input logic [15:0] b);
    urd_min = (a < b) ? a : b;
  endfunction

endpackage

// ===== logic/urd_link_if.sv
interface urd_link_if import urd_pkg::*; (input wire logic clock);
  logic setup_valid;
  logic setup_ready;
  logic [SETUP_W-1:0] setup;
  logic resp_valid;
  logic resp_ready;
  logic [ENT_W-1:0] resp_entry;

  modport device (
    input setup_valid, setup, resp_ready,
    output setup_ready, resp_valid, resp_entry
  );
  modport host (
    output setup_valid, setup, resp_ready,
    input setup_ready, resp_valid, resp_entry
  );
endinterface

// ===== logic/urd_device.sv
// Behaviour
// - Four alt settings pick poll and bulk size
// - Status interrupt endpoint always 32-byte packets
// - Set-configuration accepts only 0 or 1
// - Interface requests: interface 0, alt 0-3
// - Only device and configuration descriptors served
// - Features: remote wake-up selector only, toggles enable
// - Device status: self-powered zero, wake-up current
// - Interface status always reads all zero
// - bRequest selects control, communication or mode class
// - wValue holds command, wIndex holds parameters
// - Communication wValue splits code and embedded bits
// - Direct read: parameter byte in wValue too
// - wLength zero except command queue readback
// - Vendor commands: vendor type, device recipient
// - Undefined vendor commands answered with stall
// - Wake-up off at reset; resume on attach

module urd_fifo import urd_pkg::*; #(
  parameter int WIDTH = ENT_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr, rd, next_wr, next_rd;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready = count < (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd];

  always_comb begin
    push = ce && in_valid && in_ready;
    pop = ce && out_valid && out_ready;
    next_wr = push ? ((wr == AW'(DEPTH - 1)) ? '0 : wr + 1'b1) : wr;
    next_rd = pop ? ((rd == AW'(DEPTH - 1)) ? '0 : rd + 1'b1) : rd;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr <= '0;
      rd <= '0;
      count <= '0;
    end else if (ce) begin
      wr <= next_wr;
      rd <= next_rd;
      count <= next_count;
    end
  end

  // Storage carries no reset; only the pointers and the count need a defined value
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr] <= in_data;
    end
  end
endmodule

module urd_device import urd_pkg::*; #(
  parameter int QUEUE_DEPTH = 16,
  parameter int CTRL_CODES = 16,
  parameter int MODE_CODES = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  urd_link_if.device link,
  input wire logic bus_reset,
  input wire logic bus_suspended,
  input wire logic slave_attach,
  output logic [6:0] dev_address,
  output logic configured,
  output logic [1:0] alt_setting,
  output logic [3:0] poll_interval_ms,
  output logic [6:0] bulk_max_packet,
  output logic [6:0] intr_max_packet,
  output logic [6:0] ctrl_max_packet,
  output logic remote_wake_en,
  output logic resume_req,
  output logic cmd_valid,
  output logic [7:0] cmd_class,
  output logic [15:0] cmd_value,
  output logic [15:0] cmd_index,
  output logic [7:0] comm_code,
  output logic [7:0] comm_param,
  output logic cmd_direct_read
);
  localparam int QW = $clog2(QUEUE_DEPTH);

  urd_state_t state, next_state;
  urd_kind_t kind, next_kind;
  logic stall, next_stall;
  logic [15:0] len, next_len, idx, next_idx;
  logic [7:0] val, next_val;
  logic [6:0] next_addr;
  logic next_cfg, next_wake, next_cmd_valid, next_direct, next_resume;
  logic [1:0] next_alt;
  logic [7:0] next_class;
  logic [15:0] next_value, next_index;
  logic attach_q, next_attach;

  logic [7:0] qmem [QUEUE_DEPTH];
  logic [QW-1:0] qwr, qrd;
  logic [QW:0] qcnt;
  logic q_push, q_pop;

  logic fifo_in_valid, fifo_in_ready;
  logic [ENT_W-1:0] fifo_in_data;
  logic ok;
  logic [15:0] avail;
  logic [7:0] bmrt, breq;
  logic [15:0] wval, widx, wlen;

  assign bmrt = link.setup[BMRT_LSB +: 8];
  assign breq = link.setup[BREQ_LSB +: 8];
  assign wval = link.setup[WVAL_LSB +: 16];
  assign widx = link.setup[WIDX_LSB +: 16];
  assign wlen = link.setup[WLEN_LSB +: 16];

  assign poll_interval_ms = alt_setting[1] ? POLL_SHORT_MS : POLL_LONG_MS;
  assign bulk_max_packet = alt_setting[0] ? BULK_LARGE : BULK_SMALL;
  assign intr_max_packet = INTR_MAX_PKT;
  assign ctrl_max_packet = CTRL_MAX_PKT;
  assign comm_code = cmd_value[7:0];
  assign comm_param = cmd_value[15:8];
  assign link.setup_ready = ce && (state == URD_IDLE);

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_stall = stall;
    next_len = len;
    next_idx = idx;
    next_val = val;
    next_addr = dev_address;
    next_cfg = configured;
    next_alt = alt_setting;
    next_wake = remote_wake_en;
    next_cmd_valid = 1'b0;
    next_class = cmd_class;
    next_value = cmd_value;
    next_index = cmd_index;
    next_direct = cmd_direct_read;
    next_attach = slave_attach;
    next_resume = remote_wake_en && bus_suspended && slave_attach
                  && !attach_q;
    q_push = 1'b0;
    q_pop = 1'b0;
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    ok = 1'b0;
    avail = '0;
    unique case (state)
      URD_IDLE: begin
        if (link.setup_valid) begin
          next_kind = URD_K_VAL;
          next_val = '0;
          if (bmrt[6:5] == RT_STD) begin
            case (breq)
              REQ_GET_STATUS: begin
                if (bmrt[4:0] == RCP_DEVICE) begin
                  ok = 1'b1;
                  next_val = {6'h00, remote_wake_en, 1'b0};
                end else if (bmrt[4:0] == RCP_IFACE) begin
                  ok = widx == IFACE_NUM;
                end else if (bmrt[4:0] == RCP_EP) begin
                  ok = {widx[15:8], 1'b0, widx[6:0]} <= EP_MAX;
                end
                avail = STATUS_LEN;
              end
              REQ_CLEAR_FEATURE, REQ_SET_FEATURE: begin
                if (bmrt[4:0] == RCP_DEVICE
                    && wval == FEAT_REMOTE_WAKEUP) begin
                  ok = 1'b1;
                  next_wake = breq == REQ_SET_FEATURE;
                end
              end
              REQ_SET_ADDRESS: begin
                if (wval >= ADDR_MIN && wval <= ADDR_MAX) begin
                  ok = 1'b1;
                  next_addr = wval[6:0];
                end
              end
              REQ_GET_DESCRIPTOR: begin
                ok = wval[15:8] == DESC_DEVICE
                     || wval[15:8] == DESC_CONFIG;
                next_kind = (wval[15:8] == DESC_DEVICE) ? URD_K_DEV
                                                        : URD_K_CFG;
                avail = DESC_LEN;
              end
              REQ_GET_CONFIG: begin
                ok = 1'b1;
                next_val = {7'h00, configured};
                avail = ONE_LEN;
              end
              REQ_SET_CONFIG: begin
                if (wval <= CFG_MAX) begin
                  ok = 1'b1;
                  next_cfg = wval[0];
                  next_alt = '0;
                end
              end
              REQ_GET_IFACE: begin
                ok = bmrt[4:0] == RCP_IFACE && widx == IFACE_NUM
                     && configured;
                next_val = {6'h00, alt_setting};
                avail = ONE_LEN;
              end
              REQ_SET_IFACE: begin
                if (bmrt[4:0] == RCP_IFACE && widx == IFACE_NUM
                    && wval <= ALT_MAX && configured) begin
                  ok = 1'b1;
                  next_alt = wval[1:0];
                end
              end
              default: ok = 1'b0;
            endcase
          end else if (bmrt[6:5] == RT_VENDOR
                       && bmrt[4:0] == RCP_DEVICE) begin
            case (breq)
              CLASS_CONTROL: begin
                if (wval == COMMAND_QUEUE_READBACK) begin
                  ok = bmrt[DIR_BIT];
                  next_kind = URD_K_QUEUE;
                  avail = 16'(qcnt);
                end else begin
                  ok = wlen == '0 && wval < 16'(CTRL_CODES);
                end
              end
              BUS_COMMUNICATION_CLASS: begin
                ok = wlen == '0;
                // A full queue drops the new entry rather than stall
                q_push = ok && qcnt <= (QW+1)'(QUEUE_DEPTH - 2);
              end
              CLASS_MODE: ok = wlen == '0 && wval < 16'(MODE_CODES);
              default: ok = 1'b0;
            endcase
            if (ok) begin
              next_cmd_valid = 1'b1;
              next_class = breq;
              next_value = wval;
              next_index = widx;
              next_direct = breq == BUS_COMMUNICATION_CLASS
                            && wval[7:0] == DIRECT_READ_COMMAND;
            end
          end
          next_stall = !ok;
          next_len = ok ? urd_min(wlen, avail) : '0;
          next_idx = '0;
          next_state = ok ? URD_SEND : URD_DONE;
        end
      end
      URD_SEND: begin
        if (idx == len) begin
          next_state = URD_DONE;
        end else begin
          fifo_in_valid = ce;
          unique case (kind)
            URD_K_DEV: fifo_in_data = {2'b00, DEV_DESC[idx[2:0]]};
            URD_K_CFG: fifo_in_data = {2'b00, CFG_DESC[idx[2:0]]};
            URD_K_QUEUE: fifo_in_data = {2'b00, qmem[qrd]};
            URD_K_VAL: fifo_in_data = {2'b00, (idx == '0) ? val : 8'h00};
          endcase
          if (fifo_in_ready) begin
            next_idx = idx + 16'h0001;
            q_pop = kind == URD_K_QUEUE;
          end
        end
      end
      URD_DONE: begin
        fifo_in_valid = ce;
        fifo_in_data = {1'b1, stall, 8'h00};
        if (fifo_in_ready) begin
          next_state = URD_IDLE;
        end
      end
    endcase
    if (bus_reset) begin
      next_addr = '0;
      next_cfg = 1'b0;
      next_alt = '0;
      next_wake = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= URD_IDLE;
      kind <= URD_K_VAL;
      stall <= 1'b0;
      len <= '0;
      idx <= '0;
      val <= '0;
      dev_address <= '0;
      configured <= 1'b0;
      alt_setting <= '0;
      remote_wake_en <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_class <= '0;
      cmd_value <= '0;
      cmd_index <= '0;
      cmd_direct_read <= 1'b0;
      attach_q <= 1'b0;
      resume_req <= 1'b0;
      qwr <= '0;
      qrd <= '0;
      qcnt <= '0;
    end else if (ce) begin
      state <= next_state;
      kind <= next_kind;
      stall <= next_stall;
      len <= next_len;
      idx <= next_idx;
      val <= next_val;
      dev_address <= next_addr;
      configured <= next_cfg;
      alt_setting <= next_alt;
      remote_wake_en <= next_wake;
      cmd_valid <= next_cmd_valid;
      cmd_class <= next_class;
      cmd_value <= next_value;
      cmd_index <= next_index;
      cmd_direct_read <= next_direct;
      attach_q <= next_attach;
      resume_req <= next_resume;
      // Queue depth must be a power of two so the pointers wrap alone
      qwr <= qwr + QW'({q_push, 1'b0});
      qrd <= qrd + QW'(q_pop);
      qcnt <= qcnt + (QW+1)'({q_push, 1'b0}) - (QW+1)'(q_pop);
    end
  end

  always_ff @(posedge clock) begin
    if (ce && rst_b && q_push) begin
      qmem[qwr] <= wval[7:0];
      qmem[qwr + QW'(1)] <= wval[15:8];
    end
  end

  urd_fifo #(.WIDTH(ENT_W), .DEPTH(FIFO_DEPTH)) i_urd_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(link.resp_valid),
    .out_ready(link.resp_ready),
    .out_data(link.resp_entry)
  );
endmodule

// ===== logic/urd_host.sv
module urd_host import urd_pkg::*; (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  urd_link_if.host link,
  input wire logic user_valid,
  output logic user_ready,
  input wire logic user_raw,
  input wire logic [SETUP_W-1:0] user_setup,
  input wire logic [7:0] user_class,
  input wire logic [15:0] user_value,
  input wire logic [15:0] user_index,
  input wire logic [15:0] user_length,
  input wire logic user_dir_in,
  input wire logic user_direct_read,
  input wire logic [23:0] user_read_params,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic done,
  output logic done_stall,
  output logic rejected
);
  urd_state_t state, next_state;
  logic [SETUP_W-1:0] pkt, next_pkt, built;
  logic next_done, next_done_stall, next_rejected, bad;
  logic [15:0] wv, wi, wl;
  logic is_last;

  assign user_ready = ce && (state == URD_IDLE);
  assign link.setup_valid = ce && (state == URD_SEND);
  assign link.setup = pkt;
  assign is_last = link.resp_entry[ENT_LAST];
  assign rx_valid = (state == URD_DONE) && link.resp_valid && !is_last;
  assign rx_data = link.resp_entry[7:0];
  assign link.resp_ready = ce && (state == URD_DONE) && (is_last || rx_ready);

  always_comb begin
    wv = user_direct_read ? {user_read_params[7:0], DIRECT_READ_COMMAND}
                          : user_value;
    wi = user_direct_read ? user_read_params[23:8] : user_index;
    wl = (user_class == CLASS_CONTROL && user_value == COMMAND_QUEUE_READBACK)
         ? user_length : 16'h0000;
    built = user_raw ? user_setup
          : {wl, wi, wv, user_class,
             user_dir_in, RT_VENDOR, RCP_DEVICE};
    // Raw set-configuration and set-interface requests with out-of-range values are stopped locally
    bad = user_raw && user_setup[BMRT_LSB + 5 +: 2] == RT_STD
          && ((user_setup[BREQ_LSB +: 8] == REQ_SET_CONFIG
               && user_setup[WVAL_LSB +: 16] > CFG_MAX)
              || (user_setup[BREQ_LSB +: 8] == REQ_SET_IFACE
                  && (user_setup[WIDX_LSB +: 16] != IFACE_NUM
                      || user_setup[WVAL_LSB +: 16] > ALT_MAX)));
    next_state = state;
    next_pkt = pkt;
    next_done = 1'b0;
    next_done_stall = done_stall;
    next_rejected = 1'b0;
    unique case (state)
      URD_IDLE: begin
        if (user_valid) begin
          next_rejected = bad;
          next_pkt = built;
          next_state = bad ? URD_IDLE : URD_SEND;
        end
      end
      URD_SEND: begin
        if (link.setup_ready) begin
          next_state = URD_DONE;
        end
      end
      URD_DONE: begin
        if (link.resp_valid && is_last) begin
          next_done = 1'b1;
          next_done_stall = link.resp_entry[ENT_STALL];
          next_state = URD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= URD_IDLE;
      pkt <= '0;
      done <= 1'b0;
      done_stall <= 1'b0;
      rejected <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      pkt <= next_pkt;
      done <= next_done;
      done_stall <= next_done_stall;
      rejected <= next_rejected;
    end
  end
endmodule

// ===== dv/urd_link_monitor.sv
module urd_link_monitor import urd_pkg::*; (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic setup_valid,
  input wire logic setup_ready,
  input wire logic [SETUP_W-1:0] setup,
  input wire logic resp_valid,
  input wire logic resp_ready,
  input wire logic [ENT_W-1:0] resp_entry
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic take;
  logic vend;
  logic std;
  assign take = setup_valid && setup_ready;
  assign vend = setup_valid && setup[6:5] == RT_VENDOR;
  assign std = setup_valid && setup[6:5] == RT_STD;
  a_setup_held: assert property (
    setup_valid && !setup_ready |=> setup_valid && $stable(setup))
    else $error("setup changed before it was taken");
  a_busy_refuse: assert property (
    take |=> !setup_ready)
    else $error("second setup accepted while answering");
  a_answer_bound: assert property (
    take |=> !resp_valid ##[1:40] resp_valid)
    else $error("answer missing or too early");
  a_resp_held: assert property (
    resp_valid && !resp_ready |=> resp_valid && $stable(resp_entry))
    else $error("answer entry dropped before consumed");
  a_stall_last: assert property (
    resp_valid && resp_entry[ENT_STALL] |-> resp_entry[ENT_LAST])
    else $error("stall carried on a data entry");
  a_vendor_len: assert property (
    vend && !(setup[15:8] == CLASS_CONTROL
      && setup[31:16] == COMMAND_QUEUE_READBACK) |-> setup[63:48] == 0)
    else $error("vendor wLength not zero");
  a_vendor_rcpt: assert property (
    vend |-> setup[4:0] == RCP_DEVICE)
    else $error("vendor command not aimed at device");
  a_config_range: assert property (
    std && setup[15:8] == REQ_SET_CONFIG |-> setup[31:16] <= CFG_MAX)
    else $error("configuration value out of range");
  a_iface_range: assert property (
    std && setup[15:8] == REQ_SET_IFACE
      |-> setup[31:16] <= ALT_MAX && setup[47:32] == IFACE_NUM)
    else $error("interface or alternate out of range");
endmodule

// ===== dv/test_usb_request_decoder.sv
module test_usb_request_decoder import urd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_b, ce, bus_reset, bus_suspended, slave_attach;
  logic [6:0] dev_address, bulk_max_packet, intr_max_packet;
  logic [6:0] ctrl_max_packet;
  logic configured, remote_wake_en, resume_req, cmd_valid;
  logic cmd_direct_read;
  logic [1:0] alt_setting;
  logic [3:0] poll_interval_ms;
  logic [7:0] cmd_class, comm_code, comm_param, user_class, rx_data;
  logic [15:0] cmd_value, cmd_index, user_value, user_index;
  logic [15:0] user_length;
  logic user_valid, user_ready, user_raw, user_dir_in;
  logic user_direct_read, rx_valid, rx_ready, done, done_stall;
  logic rejected;
  logic [SETUP_W-1:0] user_setup;
  logic [23:0] user_read_params;
  logic [7:0] rx_q[$];
  logic got_rej;
  int err_total, n_compared, cyc, n_cmd, n_res, rx_hold;

  urd_link_if i_urd_link_if (.clock);
  urd_device i_urd_device (.clock, .rst_b, .ce, .link(i_urd_link_if),
    .bus_reset, .bus_suspended, .slave_attach, .dev_address, .configured,
    .alt_setting, .poll_interval_ms, .bulk_max_packet, .intr_max_packet,
    .ctrl_max_packet, .remote_wake_en, .resume_req, .cmd_valid,
    .cmd_class, .cmd_value, .cmd_index, .comm_code, .comm_param,
    .cmd_direct_read);
  urd_host i_urd_host (.clock, .rst_b, .ce, .link(i_urd_link_if),
    .user_valid, .user_ready, .user_raw, .user_setup, .user_class,
    .user_value, .user_index, .user_length, .user_dir_in,
    .user_direct_read, .user_read_params, .rx_valid, .rx_ready, .rx_data,
    .done, .done_stall, .rejected);
  urd_link_monitor i_urd_link_monitor (.clock, .rst_b,
    .setup_valid(i_urd_link_if.setup_valid),
    .setup_ready(i_urd_link_if.setup_ready),
    .setup(i_urd_link_if.setup),
    .resp_valid(i_urd_link_if.resp_valid),
    .resp_ready(i_urd_link_if.resp_ready),
    .resp_entry(i_urd_link_if.resp_entry));

  always #10 clock = ~clock;

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard: whole sequence needs well under 3000 cycles
  always @(posedge clock) begin
    cyc++;
    if (cmd_valid === 1'b1) n_cmd++;
    if (resume_req === 1'b1) n_res++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkq(string what, logic [7:0] e[$]);
    chk({what, "_len"}, 16'(e.size()), 16'(rx_q.size()));
    foreach (e[i]) chk(what, {8'h00, e[i]}, {8'h00, rx_q[i]});
  endtask

  // Request is held from a falling edge until the rising edge that takes it
  task automatic xfer(logic raw, logic [63:0] su, logic [7:0] cl,
    logic [15:0] va, logic [15:0] ix, logic [15:0] ln, logic dir);
    int n;
    rx_q = {};
    got_rej = 1'b0;
    @(negedge clock);
    user_valid = 1'b1;
    user_raw = raw;
    user_setup = su;
    user_class = cl;
    user_value = va;
    user_index = ix;
    user_length = ln;
    user_dir_in = dir;
    while (user_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    user_valid = 1'b0;
    user_direct_read = 1'b0;
    for (n = 0; n < 300; n++) begin
      // Back-pressure changes with the sample so no popped byte is missed
      rx_ready = n >= rx_hold;
      if (rejected === 1'b1) got_rej = 1'b1;
      if (done === 1'b1 || got_rej) break;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) rx_q.push_back(rx_data);
      @(negedge clock);
    end
    chk("completed", 16'h1, 16'(n < 300));
  endtask

  task automatic std(logic [7:0] rt, logic [7:0] rq, logic [15:0] va,
    logic [15:0] ix, logic [15:0] ln);
    xfer(1'b1, {ln, ix, va, rq, rt}, 8'h00, 16'h0, 16'h0, 16'h0, 1'b0);
  endtask

  task automatic vnd(logic [7:0] cl, logic [15:0] va, logic [15:0] ix,
    logic [15:0] ln, logic dir);
    xfer(1'b0, 64'h0, cl, va, ix, ln, dir);
  endtask

  initial begin
    clock = 1'b0;
    {rst_b, bus_reset, bus_suspended, slave_attach, user_valid} = '0;
    {user_raw, user_dir_in, user_direct_read} = '0;
    {user_setup, user_class, user_value, user_index, user_length} = '0;
    user_read_params = 24'h0;
    ce = 1'b1;
    rx_ready = 1'b1;
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    chk("intr_pkt", INTR_MAX_PKT, intr_max_packet);
    chk("ctrl_pkt", CTRL_MAX_PKT, ctrl_max_packet);
    chk("wake_rst", 16'h0, remote_wake_en);
    std(8'h00, REQ_SET_CONFIG, 16'h1, 16'h0, 16'h0);
    chk("configured", 16'h1, configured);
    std(8'h00, REQ_SET_CONFIG, 16'h2, 16'h0, 16'h0);
    chk("cfg2_rej", 16'h1, got_rej);
    for (logic [15:0] a = 0; a < 4; a++) begin
      std(8'h01, REQ_SET_IFACE, a, 16'h0, 16'h0);
      chk("poll", a < 2 ? 4'hA : 4'h1, poll_interval_ms);
      chk("bulk", a[0] ? 7'h40 : 7'h10, bulk_max_packet);
      chk("intr_alt", 16'h20, intr_max_packet);
      chk("ctrl_alt", 16'h8, ctrl_max_packet);
      std(8'h81, REQ_GET_IFACE, 16'h0, 16'h0, 16'h1);
      chkq("alt_read", '{a[7:0]});
    end
    std(8'h01, REQ_SET_IFACE, 16'h4, 16'h0, 16'h0);
    chk("alt4_rej", 16'h1, got_rej);
    std(8'h01, REQ_SET_IFACE, 16'h0, 16'h1, 16'h0);
    chk("if1_rej", 16'h1, got_rej);
    std(8'h80, REQ_GET_STATUS, 16'h0, 16'h0, 16'h2);
    chkq("dev_stat0", '{8'h00, 8'h00});
    std(8'h00, REQ_SET_FEATURE, FEAT_REMOTE_WAKEUP, 16'h0, 16'h0);
    chk("wake_on", 16'h1, remote_wake_en);
    std(8'h80, REQ_GET_STATUS, 16'h0, 16'h0, 16'h2);
    chkq("dev_stat1", '{8'h02, 8'h00});
    std(8'h00, REQ_SET_FEATURE, 16'h2, 16'h0, 16'h0);
    chk("feat2_stall", 16'h1, done_stall);
    std(8'h81, REQ_GET_STATUS, 16'h0, 16'h0, 16'h2);
    chkq("if_stat", '{8'h00, 8'h00});
    // Far side stalls so the answer buffer fills and must hold
    rx_hold = 30;
    std(8'h80, REQ_GET_DESCRIPTOR, 16'h0100, 16'h0, 16'h8);
    rx_hold = 0;
    chkq("dev_desc", '{DEV_DESC[0], DEV_DESC[1], DEV_DESC[2], DEV_DESC[3],
      DEV_DESC[4], DEV_DESC[5], DEV_DESC[6], DEV_DESC[7]});
    std(8'h80, REQ_GET_DESCRIPTOR, 16'h0200, 16'h0, 16'h8);
    chk("cfg_len", 16'h8, 16'(rx_q.size()));
    std(8'h80, REQ_GET_DESCRIPTOR, 16'h0300, 16'h0, 16'h8);
    chk("str_stall", 16'h1, done_stall);
    vnd(CLASS_MODE, 16'h3, 16'h0, 16'h5, 1'b0);
    chk("mode_stall", 16'h0, done_stall);
    chk("mode_class", CLASS_MODE, cmd_class);
    chk("mode_val", 16'h3, cmd_value);
    vnd(CLASS_CONTROL, 16'h1, 16'h0, 16'h0, 1'b0);
    chk("ctl_class", CLASS_CONTROL, cmd_class);
    vnd(BUS_COMMUNICATION_CLASS, 16'h1234, 16'h5678, 16'h0, 1'b0);
    chk("comm_code", 16'h34, comm_code);
    chk("comm_param", 16'h12, comm_param);
    chk("comm_index", 16'h5678, cmd_index);
    user_direct_read = 1'b1;
    user_read_params = 24'hCCBBAA;
    vnd(BUS_COMMUNICATION_CLASS, {8'h00, DIRECT_READ_COMMAND}, 16'h0,
      16'h0, 1'b0);
    chk("dr_flag", 16'h1, cmd_direct_read);
    chk("dr_value", {8'hAA, DIRECT_READ_COMMAND}, cmd_value);
    chk("dr_index", 16'hCCBB, cmd_index);
    vnd(CLASS_CONTROL, COMMAND_QUEUE_READBACK, 16'h0, 16'h4, 1'b1);
    chkq("readback", '{8'h34, 8'h12, 8'h80, 8'hAA});
    vnd(8'h05, 16'h1, 16'h0, 16'h0, 1'b0);
    chk("cls5_stall", 16'h1, done_stall);
    vnd(CLASS_MODE, 16'h8, 16'h0, 16'h0, 1'b0);
    chk("mode8_stall", 16'h1, done_stall);
    chk("cmd_count", 16'h5, 16'(n_cmd));
    bus_suspended = 1'b1;
    slave_attach = 1'b1;
    repeat (5) @(negedge clock);
    chk("resume", 16'h1, 16'(n_res));
    std(8'h00, REQ_CLEAR_FEATURE, FEAT_REMOTE_WAKEUP, 16'h0, 16'h0);
    chk("wake_off", 16'h0, remote_wake_en);
    slave_attach = 1'b0;
    repeat (2) @(negedge clock);
    slave_attach = 1'b1;
    repeat (5) @(negedge clock);
    chk("no_resume", 16'h1, 16'(n_res));
    std(8'h00, REQ_SET_FEATURE, FEAT_REMOTE_WAKEUP, 16'h0, 16'h0);
    bus_reset = 1'b1;
    repeat (2) @(negedge clock);
    bus_reset = 1'b0;
    chk("wake_busrst", 16'h0, remote_wake_en);
    chk("cfg_busrst", 16'h0, configured);
    conclude();
  end
endmodule
